// ### include/axhome_pkg.sv
package axhome_pkg;
  localparam logic [7:0] HOMING_OPCODE = 8'h0d;
  localparam logic [1:0] CMD_START = 2'h0;
  localparam logic [1:0] CMD_STOP = 2'h1;
  localparam logic [1:0] CMD_STATUS = 2'h2;
  localparam logic [7:0] MODE_SWAP_BIT = 8'h40;
  localparam logic [7:0] MODE_INV_BIT = 8'h80;
  localparam logic [5:0] MODE_BASE_MASK = 6'h3f;
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [10:0] SEARCH_SPEED_RESET = 11'h0c8;
  localparam logic [10:0] CAL_SPEED_RESET = 11'h032;
  localparam logic [10:0] STALL_SPEED_RESET = 11'h000;
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_MODE = 4'h1;
  localparam logic [3:0] ADDR_SEARCH_SPEED = 4'h2;
  localparam logic [3:0] ADDR_CAL_SPEED = 4'h3;
  localparam logic [3:0] ADDR_DISTANCE = 4'h4;
  localparam logic [3:0] ADDR_STALL_SPEED = 4'h5;
  localparam logic [3:0] ADDR_STALL_CFG = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_POSITION = 4'h8;
  localparam int BIT_START = 0;
  localparam int BIT_STOP = 1;
  localparam int BIT_STALL_EN = 0;
  localparam int BIT_ENDSTOP_L = 1;
  localparam int BIT_ENDSTOP_R = 2;

  typedef enum logic [3:0] {
    AXH_IDLE = 4'h0,
    AXH_SEEK = 4'h1,
    AXH_CREEP_OUT = 4'h2,
    AXH_REENTER = 4'h3,
    AXH_SECOND = 4'h4,
    AXH_CREEP2 = 4'h5,
    AXH_REENTER2 = 4'h6,
    AXH_DONE = 4'h7
  } axhome_state_t;

  typedef struct packed {
    logic left;
    logic right;
    logic home;
  } axhome_switch_t;

  typedef struct packed {
    logic step;
    logic dir;
    logic [10:0] speed;
  } axhome_motion_t;
endpackage

// ### logic/axhome_top.sv
`timescale 1ns/100ps
module axhome_top (
  input wire logic SYS_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic [3:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire axhome_pkg::axhome_switch_t SWITCH_IN,
  input wire logic [9:0] LOAD_IN,
  input wire logic [10:0] AXIS_SPEED_IN,
  output axhome_pkg::axhome_motion_t MOTION_OUT,
  output logic MOTOR_STOP_OUT,
  output logic HOMING_BUSY_OUT
);
  import axhome_pkg::*;

  typedef struct packed {
    axhome_state_t state;
    logic [7:0] mode;
    logic [10:0] search_speed;
    logic [10:0] cal_speed;
    logic [10:0] stall_speed;
    logic [2:0] stall_cfg;
    logic [31:0] distance;
    logic [31:0] position;
    logic [31:0] edge_a;
    logic [31:0] mark;
    logic dir;
    logic use_right;
    logic two_sided;
    logic stall_hit;
    logic ack;
    logic [31:0] rdata;
    axhome_motion_t motion;
    logic stop;
    logic busy;
  } axhome_regs_t;

  axhome_regs_t cur_r;
  axhome_regs_t cur_nxt;

  logic [5:0] base;
  logic sw_hit;
  logic lim_hit;
  logic home_mode;
  logic busy;
  logic [31:0] seen_pos;
  logic [31:0] mid_pos;
  logic [31:0] span;

  always_comb begin
    cur_nxt = cur_r;
    span = 32'h0;
    // the far side applies a step one edge after it leaves here, so the
    // switch reflects the position minus the step still in flight
    seen_pos = !cur_r.motion.step ? cur_r.position
             : cur_r.motion.dir ? cur_r.position - 32'h1
             : cur_r.position + 32'h1;
    mid_pos = 32'(($signed(cur_r.edge_a) + $signed(seen_pos)) >>> 1);
    base = cur_r.mode[5:0] & MODE_BASE_MASK;
    home_mode = (base >= 6'h05);
    // home polarity flip only applies to home-switch modes
    sw_hit = home_mode ? (SWITCH_IN.home ^ cur_r.mode[7])
           : (cur_r.use_right ? SWITCH_IN.right : SWITCH_IN.left);
    // reversal limit for modes 5 and 6; 7 and 8 ignore limits
    lim_hit = (base == 6'h05) ? SWITCH_IN.left
            : (base == 6'h06) ? SWITCH_IN.right
            : 1'b0;
    cur_nxt.ack = 1'b0;
    cur_nxt.motion.step = 1'b0;

    // bus: one wait cycle, answer on second edge
    if ((AVS_READ_IN || AVS_WRITE_IN) && !cur_r.ack) begin
      cur_nxt.ack = 1'b1;
      cur_nxt.rdata = 32'h0;
      if (AVS_WRITE_IN) begin
        unique case (AVS_ADDRESS_IN)
          ADDR_CONTROL: begin
            if (AVS_WRITEDATA_IN[15:8] == HOMING_OPCODE) begin
              if (AVS_WRITEDATA_IN[1:0] == CMD_START &&
                  cur_r.state == AXH_IDLE) begin
                cur_nxt.state = AXH_SEEK;
                cur_nxt.stop = 1'b0;
                cur_nxt.stall_hit = 1'b0;
                // mode 2/3 swap means start on left, else right
                cur_nxt.use_right = (base == 6'h02 || base == 6'h03)
                  ? !cur_r.mode[6] : cur_r.mode[6];
                cur_nxt.two_sided = (base != 6'h01 && base != 6'h02);
                cur_nxt.dir = (base == 6'h06 || base == 6'h07) ? 1'b1
                  : (base == 6'h02 || base == 6'h03) ? !cur_r.mode[6]
                  : (base <= 6'h04) ? cur_r.mode[6] : 1'b0;
                cur_nxt.mark = cur_r.position;
              end else if (AVS_WRITEDATA_IN[1:0] == CMD_STOP) begin
                cur_nxt.state = AXH_IDLE;
              end
            end
          end
          ADDR_MODE: cur_nxt.mode = AVS_WRITEDATA_IN[7:0];
          ADDR_SEARCH_SPEED: cur_nxt.search_speed = AVS_WRITEDATA_IN[10:0];
          ADDR_CAL_SPEED: cur_nxt.cal_speed = AVS_WRITEDATA_IN[10:0];
          ADDR_STALL_SPEED: cur_nxt.stall_speed = AVS_WRITEDATA_IN[10:0];
          ADDR_STALL_CFG: cur_nxt.stall_cfg = AVS_WRITEDATA_IN[2:0];
          ADDR_POSITION: cur_nxt.position = AVS_WRITEDATA_IN;
          default: ;
        endcase
      end else begin
        unique case (AVS_ADDRESS_IN)
          ADDR_CONTROL: cur_nxt.rdata = {28'h0, cur_r.state};
          ADDR_MODE: cur_nxt.rdata = {24'h0, cur_r.mode};
          ADDR_SEARCH_SPEED: cur_nxt.rdata = {21'h0, cur_r.search_speed};
          ADDR_CAL_SPEED: cur_nxt.rdata = {21'h0, cur_r.cal_speed};
          ADDR_DISTANCE: cur_nxt.rdata = cur_r.distance;
          ADDR_STALL_SPEED: cur_nxt.rdata = {21'h0, cur_r.stall_speed};
          ADDR_STALL_CFG: cur_nxt.rdata = {29'h0, cur_r.stall_cfg};
          ADDR_STATUS: cur_nxt.rdata = {29'h0, cur_r.stall_hit,
                         cur_r.stop, cur_r.state != AXH_IDLE};
          ADDR_POSITION: cur_nxt.rdata = cur_r.position;
          default: cur_nxt.rdata = 32'h0;
        endcase
      end
    end

    // stall: load falls to zero at max load; gated by speed threshold
    if (cur_r.stall_cfg[BIT_STALL_EN] && LOAD_IN == 10'h000 &&
        AXIS_SPEED_IN > cur_r.stall_speed) begin
      cur_nxt.stop = 1'b1;
      cur_nxt.stall_hit = 1'b1;
      cur_nxt.state = AXH_IDLE;
    end else if (cur_r.state == AXH_IDLE && cur_r.stall_cfg[BIT_ENDSTOP_L]
                 && SWITCH_IN.left) begin
      // end-stop auto stop only outside homing
      cur_nxt.stop = 1'b1;
    end else if (cur_r.state == AXH_IDLE && cur_r.stall_cfg[BIT_ENDSTOP_R]
                 && SWITCH_IN.right) begin
      cur_nxt.stop = 1'b1;
    end else if (cur_r.state != AXH_IDLE && cur_r.state != AXH_DONE) begin
      cur_nxt.stop = 1'b0;
      cur_nxt.motion.step = 1'b1;
      cur_nxt.position = cur_r.dir ? cur_r.position + 32'h1
                                   : cur_r.position - 32'h1;
      cur_nxt.motion.dir = cur_r.dir;
      unique case (cur_r.state)
        AXH_SEEK: begin
          cur_nxt.motion.speed = cur_r.search_speed;
          // turn away from the limit, never toggle while it stays active
          if (lim_hit) begin
            cur_nxt.dir = (base == 6'h05);
          end
          if (sw_hit) begin
            cur_nxt.edge_a = seen_pos;
            cur_nxt.state = AXH_CREEP_OUT;
          end
        end
        AXH_CREEP_OUT: begin
          cur_nxt.motion.speed = cur_r.cal_speed;
          if (!sw_hit) begin
            cur_nxt.dir = !cur_r.dir;
            cur_nxt.state = AXH_REENTER;
          end
        end
        AXH_REENTER: begin
          cur_nxt.motion.speed = cur_r.cal_speed;
          if (sw_hit) begin
            cur_nxt.state = AXH_DONE;
            // midpoint of the two switching points
            cur_nxt.mark = mid_pos;
            if (!home_mode && !cur_r.two_sided) begin
              cur_nxt.mark = cur_r.edge_a;
            end
            if (base == 6'h02 || base == 6'h03) begin
              cur_nxt.state = AXH_SECOND;
              // already heading toward the second switch; keep direction
              cur_nxt.use_right = !cur_r.use_right;
              cur_nxt.mark = cur_r.edge_a;
            end
          end
        end
        AXH_SECOND: begin
          cur_nxt.motion.speed = cur_r.search_speed;
          if (sw_hit) begin
            cur_nxt.edge_a = seen_pos;
            if (base == 6'h02) begin
              span = seen_pos - cur_r.mark;
              cur_nxt.distance = span[31] ? -span : span;
              cur_nxt.mark = seen_pos;
              cur_nxt.state = AXH_DONE;
            end else begin
              cur_nxt.state = AXH_CREEP2;
            end
          end
        end
        AXH_CREEP2: begin
          cur_nxt.motion.speed = cur_r.cal_speed;
          if (!sw_hit) begin
            cur_nxt.dir = !cur_r.dir;
            cur_nxt.state = AXH_REENTER2;
          end
        end
        AXH_REENTER2: begin
          cur_nxt.motion.speed = cur_r.cal_speed;
          if (sw_hit) begin
            span = mid_pos - cur_r.mark;
            cur_nxt.distance = span[31] ? -span : span;
            cur_nxt.mark = mid_pos;
            cur_nxt.state = AXH_DONE;
          end
        end
        default: ;
      endcase
    end else if (cur_r.state == AXH_DONE) begin
      // reference becomes zero; no step this cycle
      cur_nxt.position = cur_r.position - cur_r.mark;
      cur_nxt.state = AXH_IDLE;
    end
    busy = (cur_nxt.state != AXH_IDLE);
    cur_nxt.busy = busy;
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cur_r <= '0;
      cur_r.mode <= MODE_RESET;
      cur_r.search_speed <= SEARCH_SPEED_RESET;
      cur_r.cal_speed <= CAL_SPEED_RESET;
      cur_r.stall_speed <= STALL_SPEED_RESET;
      cur_r.state <= AXH_IDLE;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  always_comb begin
    AVS_READDATA_OUT = cur_r.rdata;
    AVS_WAITREQUEST_OUT = !cur_r.ack;
    MOTION_OUT = cur_r.motion;
    MOTOR_STOP_OUT = cur_r.stop;
    HOMING_BUSY_OUT = cur_r.busy;
  end
endmodule

// ### bench/axhome_properties.sv
`timescale 1ns/100ps
module axhome_properties
  import axhome_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic [3:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic AVS_WAITREQUEST_OUT,
  input wire axhome_pkg::axhome_switch_t SWITCH_IN,
  input wire logic [9:0] LOAD_IN,
  input wire logic [10:0] AXIS_SPEED_IN,
  input wire axhome_pkg::axhome_motion_t MOTION_OUT,
  input wire logic MOTOR_STOP_OUT,
  input wire logic HOMING_BUSY_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  logic wr_done;
  logic ctl_ok;
  logic en_r;
  logic [10:0] thr_r;
  assign wr_done = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
  assign ctl_ok = wr_done && AVS_ADDRESS_IN == ADDR_CONTROL &&
    AVS_WRITEDATA_IN[15:8] == HOMING_OPCODE;
  // shadow of the stall setup, one cycle late, so bounds allow slack
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      en_r <= 1'b0;
      thr_r <= STALL_SPEED_RESET;
    end else if (wr_done && AVS_ADDRESS_IN == ADDR_STALL_CFG) begin
      en_r <= AVS_WRITEDATA_IN[BIT_STALL_EN];
    end else if (wr_done && AVS_ADDRESS_IN == ADDR_STALL_SPEED) begin
      thr_r <= AVS_WRITEDATA_IN[10:0];
    end
  end
  one_wait_a:
    assert property ($rose(AVS_READ_IN || AVS_WRITE_IN) |->
      AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT) else $error("late ack");
  ack_pulse_a:
    assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("ack too long");
  unmapped_zero_a:
    assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT &&
      AVS_ADDRESS_IN > ADDR_POSITION |-> AVS_READDATA_OUT == 32'h0)
    else $error("unmapped read not zero");
  start_busy_a:
    assert property (ctl_ok && AVS_WRITEDATA_IN[1:0] == CMD_START |->
      ##[0:2] HOMING_BUSY_OUT) else $error("start ignored");
  bad_code_a:
    assert property (wr_done && AVS_ADDRESS_IN == ADDR_CONTROL &&
      AVS_WRITEDATA_IN[15:8] != HOMING_OPCODE && !HOMING_BUSY_OUT |->
      !HOMING_BUSY_OUT [*3]) else $error("bad code started homing");
  stop_idle_a:
    assert property (ctl_ok && AVS_WRITEDATA_IN[1:0] == CMD_STOP |->
      ##[0:4] !HOMING_BUSY_OUT) else $error("stop ignored");
  step_busy_a:
    assert property (MOTION_OUT.step |->
      HOMING_BUSY_OUT || $past(HOMING_BUSY_OUT)) else $error("stray step");
  stall_stop_a:
    assert property (en_r && AXIS_SPEED_IN > thr_r && LOAD_IN == 10'h000
      |-> ##[1:3] MOTOR_STOP_OUT) else $error("no stall stop");
  cover property ($rose(HOMING_BUSY_OUT));
  cover property ($rose(MOTOR_STOP_OUT));
  cover property (AVS_READ_IN && !AVS_WAITREQUEST_OUT);
endmodule

// ### bench/axhome_partner.sv
`timescale 1ns/100ps
// ideal slide with switches, no bounce: real contacts would chatter
module axhome_partner
  import axhome_pkg::*;
#(
  parameter int LEFT_FAR = -230,
  parameter int LEFT_NEAR = -200,
  parameter int RIGHT_NEAR = 200,
  parameter int RIGHT_FAR = 230,
  parameter int HOME_LO = 50,
  parameter int HOME_HI = 70
)(
  input wire logic clk_in,
  input wire axhome_pkg::axhome_motion_t motion_in,
  input wire logic park_in,
  input wire logic signed [31:0] park_pos_in,
  output axhome_pkg::axhome_switch_t switch_out,
  output logic signed [31:0] pos_out
);
  always_ff @(posedge clk_in) begin
    if (park_in) begin
      pos_out <= park_pos_in;
    end else if (motion_in.step) begin
      pos_out <= motion_in.dir ? pos_out + 1 : pos_out - 1;
    end
  end
  // end switches have a far edge so both sides can be found
  assign switch_out.left = pos_out >= LEFT_FAR && pos_out <= LEFT_NEAR;
  assign switch_out.right = pos_out >= RIGHT_NEAR && pos_out <= RIGHT_FAR;
  assign switch_out.home = pos_out >= HOME_LO && pos_out <= HOME_HI;
endmodule

// ### bench/tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
  $display("Error %0t: got %0h want %0h", $time, a, e); end end
module tb_top;
  import axhome_pkg::*;
  localparam logic [7:0] MODES [10] = '{8'h01, 8'h41, 8'h02, 8'h42, 8'h03,
    8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
  localparam int PARK [10] = '{0, 0, 0, 0, 0, 0, -100, 100, 0, 100};
  localparam logic [9:0] DIRS = 10'h196;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic park = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [9:0] load = 10'h3ff;
  logic [10:0] spd = 11'h000;
  logic signed [31:0] ppos = 32'h0;
  logic [31:0] rdata;
  logic wreq;
  logic stop;
  logic busy;
  logic signed [31:0] pos;
  axhome_switch_t sw;
  axhome_motion_t mot;
  int bad_count = 0;
  int n_tests = 0;
  int hi;
  int cal;
  axhome_top i_dut (.SYS_CLK_IN(clk), .RESETN_IN(rstn),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
    .AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata),
    .AVS_WAITREQUEST_OUT(wreq), .SWITCH_IN(sw), .LOAD_IN(load),
    .AXIS_SPEED_IN(spd), .MOTION_OUT(mot), .MOTOR_STOP_OUT(stop),
    .HOMING_BUSY_OUT(busy));
  axhome_partner i_far (.clk_in(clk), .motion_in(mot), .park_in(park),
    .park_pos_in(ppos), .switch_out(sw), .pos_out(pos));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic oops(input string m);
    bad_count++;
    $display("Error %0t: %s", $time, m);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (n >= 20) oops("bus hang");
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic stall(input logic [10:0] s, input logic [9:0] l,
      input logic e);
    spd <= s;
    load <= l;
    repeat (4) @(posedge clk);
    `CHK(stop, e)
  endtask
  task automatic to_pos(input logic [31:0] p);
    park <= 1'b1;
    ppos <= p;
    @(posedge clk);
    park <= 1'b0;
  endtask
  task automatic run(input int i);
    int n;
    n = 0;
    hi = 0;
    cal = 0;
    to_pos(PARK[i]);
    wreg(ADDR_MODE, 32'(MODES[i]));
    wreg(ADDR_CONTROL, 32'h0d00);
    while (mot.step !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    `CHK(mot.dir, DIRS[i])
    `CHK(mot.speed, SEARCH_SPEED_RESET)
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
      if (stop === 1'b1) hi++;
      if (mot.step === 1'b1 && mot.speed === CAL_SPEED_RESET) cal++;
    end
    if (n >= 5000) oops("homing hang");
    `CHK(hi, 0)
    if (i == 2) rchk(ADDR_DISTANCE, 32'h190);
    if (i == 4) rchk(ADDR_DISTANCE, 32'h19f);
    if (i == 5) rchk(ADDR_POSITION, pos + 32'hd7);
    if (i == 5) `CHK(cal > 0, 1'b1)
    if (i == 8) rchk(ADDR_POSITION, pos - 32'h3c);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    park <= 1'b0;
    rchk(ADDR_MODE, 32'(MODE_RESET));
    rchk(ADDR_SEARCH_SPEED, 32'(SEARCH_SPEED_RESET));
    rchk(ADDR_CAL_SPEED, 32'(CAL_SPEED_RESET));
    rchk(4'hf, 32'h0);
    wreg(ADDR_CONTROL, 32'h0c00);
    repeat (3) @(posedge clk);
    `CHK(busy, 1'b0)
    wreg(ADDR_STALL_SPEED, 32'ha);
    wreg(ADDR_STALL_CFG, 32'h1);
    stall(11'h14, 10'h5, 1'b0);
    stall(11'h5, 10'h0, 1'b0);
    stall(11'h14, 10'h0, 1'b1);
    rchk(ADDR_STATUS, 32'h6);
    rstn <= 1'b0;
    load <= 10'h3ff;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    wreg(ADDR_STALL_CFG, 32'h6);
    for (int i = 0; i < 10; i++) begin
      run(i);
    end
    // far from home so only the stop can end it
    to_pos(32'hfffffc18);
    wreg(ADDR_CONTROL, 32'h0d00);
    wreg(ADDR_CONTROL, 32'h0d01);
    repeat (5) @(posedge clk);
    `CHK(busy, 1'b0)
    give_verdict();
  end
  initial begin
    #1000000;
    oops("watchdog");
    give_verdict();
  end
endmodule
bind axhome_top axhome_properties i_props (.SYS_CLK_IN, .RESETN_IN,
  .AVS_ADDRESS_IN, .AVS_READ_IN, .AVS_WRITE_IN, .AVS_WRITEDATA_IN,
  .AVS_READDATA_OUT, .AVS_WAITREQUEST_OUT, .SWITCH_IN, .LOAD_IN,
  .AXIS_SPEED_IN, .MOTION_OUT, .MOTOR_STOP_OUT, .HOMING_BUSY_OUT);
